// File: dcfs_pkg.sv
package dcfs_pkg;

  // ----------------------------------------------------------------------
  // object indices
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_PULSE_MODE   = 16'h205B;
  localparam logic [15:0] IDX_BOOT_DELAY   = 16'h2084;
  localparam logic [15:0] IDX_AVAIL_MAP    = 16'h2101;
  localparam logic [15:0] IDX_ENABLE_CTRL  = 16'h2102;
  localparam logic [15:0] IDX_MODULE_STAT  = 16'h2103;
  localparam logic [7:0]  SUB_MAIN         = 8'h00;
  localparam logic [7:0]  SUB_DISABLE_MASK = 8'h01;
  localparam logic [7:0]  SUB_ENABLED      = 8'h02;
  localparam logic [31:0] STAT_HIGHEST_SUB = 32'h00000002;

  // ----------------------------------------------------------------------
  // bit positions
  // ----------------------------------------------------------------------
  localparam int BIT_USB                       = 0;
  localparam int BIT_RS485                     = 1;
  localparam int BIT_RS232                     = 2;
  localparam int BIT_CAN                       = 3;
  localparam int BIT_ETHERNET_PHYS_BIT         = 4;
  localparam int BIT_REALTIME_INDUSTRIAL_ETH   = 5;
  localparam int BIT_SPI                       = 6;
  localparam int BIT_SERIAL_MODBUS_PROTO       = 16;
  localparam int BIT_TCP_MODBUS_PROTO          = 17;
  localparam int BIT_CIP_ETHERNET_PROTO        = 18;

  // assigned positions: bits 0..6 and 16..18
  localparam logic [31:0] ASSIGNED_MASK    = 32'h0007007F;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_PULSE_MODE   = 32'h00000000;
  localparam logic [31:0] RST_BOOT_DELAY   = 32'h00000000;
  localparam logic [31:0] RST_AVAIL_MAP    = 32'h00010012;
  localparam logic [31:0] RST_ENABLE_CTRL  = 32'h00010012;
  localparam logic [31:0] RST_DISABLE_MASK = 32'h00000012;

  localparam logic [31:0] PULSE_MODE_STEP_DIR = 32'h00000000;
  localparam logic [31:0] PULSE_MODE_CW_CCW   = 32'h00000001;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  typedef enum logic [2:0] {
    DCFS_BOOT_HOLD  = 3'b001,
    DCFS_BOOT_COUNT = 3'b010,
    DCFS_BOOT_READY = 3'b100
  } dcfs_boot_state_t;

endpackage : dcfs_pkg

// File: dcfs_tick_if.sv
interface dcfs_tick_if;
  logic ms_tick;
  logic run;
  modport source (input run, output ms_tick);
  modport sink   (output run, input ms_tick);
endinterface : dcfs_tick_if

// File: dcfs_ms_divider.sv
module dcfs_ms_divider (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  dcfs_tick_if.source tick
);

  localparam logic [16:0] LAST = 17'(dcfs_pkg::CYCLES_PER_MS - 1);

  logic [16:0] count;
  logic [16:0] next_count;
  logic        pulse;
  logic        next_pulse;

  always_comb begin
    next_count = count;
    next_pulse = 1'b0;
    if (!tick.run) begin
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_pulse = 1'b1;
    end else begin
      next_count = count + 17'h00001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end

  assign tick.ms_tick = pulse;

endmodule : dcfs_ms_divider

// File: dcfs_config_bank.sv
// Overview of operation
// RULE_01: pulse mode object value 0 selects step plus direction, value 1 selects cw/ccw pulses.
// RULE_02: boot delay object holds the milliseconds waited after power-up before ready.
// RULE_03: bitmap bits 0-15 denote physical interfaces and bits 16-31 denote protocols.
// RULE_04: availability bits 0..6 mark USB, RS-485, RS-232, CAN, Ethernet, realtime eth, SPI.
// RULE_05: availability bits 16..18 mark Modbus RTU, Modbus TCP and CIP protocol in use.
// RULE_06: the availability bitmap is read-only and writes leave it unchanged.
// RULE_07: the control object switches interfaces and protocols with the same bit layout.
// RULE_08: only bits in the switchable-capability mask can be switched through control.
// RULE_09: the active set is reported in a separate read-only enabled-status bitmap.
// RULE_10: a 1 in the switchable-capability mask means that entry can be deactivated.
// RULE_11: a 1 in the enabled-status bitmap means that entry is currently active.
// RULE_12: control bits for entries outside the mask are ignored and keep their state.
// RULE_13: unassigned bit positions 7-15 and 19-31 read as zero.
module dcfs_config_bank (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        obj_wr_i,
  input  wire logic        obj_rd_i,
  input  wire logic [15:0] obj_index_i,
  input  wire logic [7:0]  obj_sub_i,
  input  wire logic [31:0] obj_wdata_i,
  output logic      [31:0] obj_rdata_o,
  output logic             obj_ack_o,
  output logic             obj_err_o,
  output logic             pulse_cw_ccw_o,
  output logic             ready_o,
  output logic      [31:0] fieldbus_enabled_o
);

  // ----------------------------------------------------------------------
  // object storage
  // ----------------------------------------------------------------------
  logic [31:0] pulse_mode;
  logic [31:0] boot_delay;
  logic [31:0] enable_ctrl;
  logic [31:0] next_pulse_mode;
  logic [31:0] next_boot_delay;
  logic [31:0] next_enable_ctrl;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        ack;
  logic        next_ack;
  logic        err;
  logic        next_err;
  logic        cw_ccw;
  logic        next_cw_ccw;
  logic [31:0] enabled;
  logic [31:0] next_enabled;

  // fixed capabilities: presence and switchability are properties of the build
  localparam logic [31:0] AVAIL = dcfs_pkg::RST_AVAIL_MAP & dcfs_pkg::ASSIGNED_MASK;   // RULE_13
  localparam logic [31:0] SWMASK = dcfs_pkg::RST_DISABLE_MASK & dcfs_pkg::ASSIGNED_MASK;

  logic sel_main;
  logic hit_mode;
  logic hit_delay;
  logic hit_avail;
  logic hit_ctrl;
  logic hit_stat;

  assign sel_main  = (obj_sub_i == dcfs_pkg::SUB_MAIN);
  assign hit_mode  = sel_main && (obj_index_i == dcfs_pkg::IDX_PULSE_MODE);
  assign hit_delay = sel_main && (obj_index_i == dcfs_pkg::IDX_BOOT_DELAY);
  assign hit_avail = sel_main && (obj_index_i == dcfs_pkg::IDX_AVAIL_MAP);
  assign hit_ctrl  = sel_main && (obj_index_i == dcfs_pkg::IDX_ENABLE_CTRL);
  assign hit_stat  = (obj_index_i == dcfs_pkg::IDX_MODULE_STAT) &&
                     (obj_sub_i <= dcfs_pkg::SUB_ENABLED);

  // ----------------------------------------------------------------------
  // object access
  // ----------------------------------------------------------------------
  always_comb begin
    next_pulse_mode  = pulse_mode;
    next_boot_delay  = boot_delay;
    next_enable_ctrl = enable_ctrl;
    next_rdata       = rdata;
    next_ack         = 1'b0;
    next_err         = 1'b0;
    if (obj_wr_i) begin
      next_ack = 1'b1;
      if (hit_mode) begin
        next_pulse_mode = obj_wdata_i;
      end else if (hit_delay) begin
        next_boot_delay = obj_wdata_i;   // RULE_02
      end else if (hit_ctrl) begin
        // non-switchable entries keep their present value
        next_enable_ctrl = ((obj_wdata_i & SWMASK) | (enable_ctrl & ~SWMASK))
                           & dcfs_pkg::ASSIGNED_MASK;   // RULE_07 RULE_08 RULE_12 RULE_13
      end else begin
        // availability and status objects refuse writes
        next_err = 1'b1;   // RULE_06 RULE_09
      end
    end else if (obj_rd_i) begin
      next_ack = 1'b1;
      if (hit_mode) begin
        next_rdata = pulse_mode;
      end else if (hit_delay) begin
        next_rdata = boot_delay;
      end else if (hit_avail) begin
        next_rdata = AVAIL;   // RULE_03 RULE_04 RULE_05 RULE_06
      end else if (hit_ctrl) begin
        next_rdata = enable_ctrl;
      end else if (hit_stat) begin
        unique case (obj_sub_i)
          dcfs_pkg::SUB_MAIN:         next_rdata = dcfs_pkg::STAT_HIGHEST_SUB;
          dcfs_pkg::SUB_DISABLE_MASK: next_rdata = SWMASK;   // RULE_10
          default:                    next_rdata = enabled;   // RULE_09 RULE_11
        endcase
      end else begin
        next_rdata = 32'h00000000;
        next_err   = 1'b1;
      end
    end
  end

  // protocol bits are not physical presence, so they pass on the control alone
  localparam logic [31:0] AVAIL_OR_PROTO = AVAIL | 32'h00070000;
  // active set: only present entries can ever be active
  always_comb begin
    next_enabled = enable_ctrl & AVAIL_OR_PROTO;   // RULE_11
    next_cw_ccw  = (pulse_mode == dcfs_pkg::PULSE_MODE_CW_CCW);   // RULE_01
  end


  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pulse_mode  <= dcfs_pkg::RST_PULSE_MODE;
      boot_delay  <= dcfs_pkg::RST_BOOT_DELAY;
      enable_ctrl <= dcfs_pkg::RST_ENABLE_CTRL;
      rdata       <= 32'h00000000;
      ack         <= 1'b0;
      err         <= 1'b0;
      cw_ccw      <= 1'b0;
      enabled     <= 32'h00000000;
    end else begin
      pulse_mode  <= next_pulse_mode;
      boot_delay  <= next_boot_delay;
      enable_ctrl <= next_enable_ctrl;
      rdata       <= next_rdata;
      ack         <= next_ack;
      err         <= next_err;
      cw_ccw      <= next_cw_ccw;
      enabled     <= next_enabled;
    end
  end

  // ----------------------------------------------------------------------
  // boot delay
  // ----------------------------------------------------------------------
  // the delay is latched at the first cycle after reset; later writes do not
  // touch the running count, and reset loads RST_BOOT_DELAY back into the object
  dcfs_tick_if tick ();
  dcfs_ms_divider dcfs_ms_divider_i (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick   (tick.source)
  );

  dcfs_pkg::dcfs_boot_state_t state;
  dcfs_pkg::dcfs_boot_state_t next_state;
  logic [31:0] ms_left;
  logic [31:0] next_ms_left;
  logic        rdy;
  logic        next_rdy;

  assign tick.run = (state == dcfs_pkg::DCFS_BOOT_COUNT);

  always_comb begin
    next_state   = state;
    next_ms_left = ms_left;
    next_rdy     = rdy;
    unique case (state)
      dcfs_pkg::DCFS_BOOT_HOLD: begin
        next_ms_left = boot_delay;
        if (boot_delay == 32'h00000000) begin
          next_state = dcfs_pkg::DCFS_BOOT_READY;
          next_rdy   = 1'b1;
        end else begin
          next_state = dcfs_pkg::DCFS_BOOT_COUNT;
        end
      end
      dcfs_pkg::DCFS_BOOT_COUNT: begin
        if (tick.ms_tick) begin
          if (ms_left == 32'h00000001) begin
            next_state = dcfs_pkg::DCFS_BOOT_READY;   // RULE_02
            next_rdy   = 1'b1;
          end
          next_ms_left = ms_left - 32'h00000001;
        end
      end
      dcfs_pkg::DCFS_BOOT_READY: begin
        next_rdy = 1'b1;
      end
      default: begin
        next_state = dcfs_pkg::DCFS_BOOT_HOLD;
        next_rdy   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state   <= dcfs_pkg::DCFS_BOOT_HOLD;
      ms_left <= 32'h00000000;
      rdy     <= 1'b0;
    end else begin
      state   <= next_state;
      ms_left <= next_ms_left;
      rdy     <= next_rdy;
    end
  end

  assign obj_rdata_o        = rdata;
  assign obj_ack_o          = ack;
  assign obj_err_o          = err;
  assign pulse_cw_ccw_o     = cw_ccw;
  assign ready_o            = rdy;
  assign fieldbus_enabled_o = enabled;

endmodule : dcfs_config_bank

// File: dcfs_checker.sv
module dcfs_checker (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        obj_wr_i,
  input wire logic        obj_rd_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0]  obj_sub_i,
  input wire logic [31:0] obj_wdata_i,
  input wire logic [31:0] obj_rdata_o,
  input wire logic        obj_ack_o,
  input wire logic        obj_err_o,
  input wire logic        pulse_cw_ccw_o,
  input wire logic        ready_o,
  input wire logic [31:0] fieldbus_enabled_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------------------
  // request shapes
  // ----------------------------------------------------------------------
  sequence s_req;
    obj_wr_i || obj_rd_i;
  endsequence
  sequence s_wr(x);
    obj_wr_i && obj_index_i == x && obj_sub_i == 8'h00;
  endsequence
  sequence s_rd(x);
    obj_rd_i && !obj_wr_i && obj_index_i == x;
  endsequence
  property p_ack;
    s_req |=> obj_ack_o;
  endproperty
  property p_idle;
    !(obj_wr_i || obj_rd_i) |=> !obj_ack_o && !obj_err_o;
  endproperty
  property p_ro;
    s_wr(16'h2101) |=> obj_ack_o && obj_err_o;
  endproperty
  property p_avail;
    s_rd(16'h2101) ##0 obj_sub_i == 8'h00 |=> obj_rdata_o == 32'h00010012 && !obj_err_o;
  endproperty
  property p_mask;
    s_rd(16'h2103) ##0 obj_sub_i == 8'h01 |=> obj_rdata_o == 32'h00000012;
  endproperty
  // enabled follows control one edge after control takes the write
  property p_switch;
    s_wr(16'h2102) |-> ##2 (fieldbus_enabled_o & 32'h12) == ($past(obj_wdata_i, 2) & 32'h12);
  endproperty
  property p_fixed;
    $past(rstn_i) |-> (fieldbus_enabled_o & ~32'h12) == 32'h00010000;
  endproperty
  property p_mode;
    s_wr(16'h205B) |-> ##2 pulse_cw_ccw_o == ($past(obj_wdata_i, 2) == 32'h1);
  endproperty
  property p_ready;
    ready_o |=> ready_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  a_idle: assert property (p_idle) else $error("stray ack");
  a_ro: assert property (p_ro) else $error("ro write ok");
  a_avail: assert property (p_avail) else $error("bad avail");
  a_mask: assert property (p_mask) else $error("bad mask");
  a_switch: assert property (p_switch) else $error("bad switch");
  a_fixed: assert property (p_fixed) else $error("fixed bit moved");
  a_mode: assert property (p_mode) else $error("bad mode");
  a_ready: assert property (p_ready) else $error("ready fell");
endmodule : dcfs_checker

bind dcfs_config_bank dcfs_checker dcfs_checker_i (.clk_i, .rstn_i, .obj_wr_i, .obj_rd_i,
  .obj_index_i, .obj_sub_i, .obj_wdata_i, .obj_rdata_o, .obj_ack_o, .obj_err_o,
  .pulse_cw_ccw_o, .ready_o, .fieldbus_enabled_o);

// File: dcfs_config_bank_tb.sv
module dcfs_config_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rstn_i;
  logic        obj_wr_i;
  logic        obj_rd_i;
  logic [15:0] obj_index_i;
  logic [7:0]  obj_sub_i;
  logic [31:0] obj_wdata_i;
  logic [31:0] obj_rdata_o;
  logic        obj_ack_o;
  logic        obj_err_o;
  logic        pulse_cw_ccw_o;
  logic        ready_o;
  logic [31:0] fieldbus_enabled_o;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] d;
  int          fails;
  int          check_count;
  int          cycles;
  logic [15:0] ix[8] = '{16'h205B, 16'h2084, 16'h2101, 16'h2102, 16'h2103, 16'h2103, 16'h2103, 16'h1234};
  logic [7:0]  sb[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
  logic [31:0] rv[8] = '{32'h0, 32'h0, 32'h10012, 32'h10012, 32'h2, 32'h12, 32'h10012, 32'h0};

  dcfs_config_bank dcfs_config_bank_i (.clk_i, .rstn_i, .obj_wr_i, .obj_rd_i, .obj_index_i,
    .obj_sub_i, .obj_wdata_i, .obj_rdata_o, .obj_ack_o, .obj_err_o, .pulse_cw_ccw_o, .ready_o,
    .fieldbus_enabled_o);

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // read data is only noted for reads that are meant to succeed
  task acc(input logic w, input logic [15:0] x, input logic [7:0] s, input logic [31:0] wd,
           input logic er, input logic [31:0] r);
    exp_q.push_back({!w && !er, er, r});
    obj_wr_i = w;
    obj_rd_i = !w;
    obj_index_i = x;
    obj_sub_i = s;
    obj_wdata_i = wd;
    @(posedge clk_i);
    #1;
  endtask : acc

  task idle(input int n);
    obj_wr_i = 1'b0;
    obj_rd_i = 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  task do_reset;
    rstn_i = 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------------
  // answer watcher
  // ----------------------------------------------------------------------
  // answers are looked at mid-cycle, well away from the edge that launches them
  always @(negedge clk_i) begin
    cycles++;
    if (cycles > 2000) begin
      fails++;
      end_of_test();
    end else if (obj_ack_o === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      check({31'h0, obj_err_o}, {31'h0, e[32]});
      if (e[33]) check(obj_rdata_o, e[31:0]);
    end
  end

  initial begin
    fails = 0;
    check_count = 0;
    cycles = 0;
    rstn_i = 1'b0;
    obj_wr_i = 1'b0;
    obj_rd_i = 1'b0;
    obj_index_i = 16'h0;
    obj_sub_i = 8'h0;
    obj_wdata_i = 32'h0;
    d = $urandom(32'h4bf9f61c);
    do_reset();
    check({31'h0, ready_o}, 32'h0);
    idle(3);
    check({31'h0, ready_o}, 32'h1);
    check(fieldbus_enabled_o, 32'h00010012);
    for (int i = 0; i < 8; i++) acc(1'b0, ix[i], sb[i], 32'h0, i == 7, rv[i]);
    acc(1'b1, 16'h2101, 8'h00, $urandom, 1'b1, 32'h0);
    acc(1'b1, 16'h2103, 8'h02, 32'hFFFFFFFF, 1'b1, 32'h0);
    acc(1'b1, 16'h1234, 8'h00, 32'hFFFFFFFF, 1'b1, 32'h0);
    acc(1'b0, 16'h2101, 8'h00, 32'h0, 1'b0, 32'h10012);
    for (int i = 0; i < 6; i++) begin
      d = i == 0 ? 32'h0 : (i == 1 ? 32'hFFFFFFFF : $urandom);
      acc(1'b1, 16'h2102, 8'h00, d, 1'b0, 32'h0);
      acc(1'b0, 16'h2102, 8'h00, 32'h0, 1'b0, (d & 32'h12) | 32'h10000);
      idle(1);
      acc(1'b0, 16'h2103, 8'h02, 32'h0, 1'b0, (d & 32'h12) | 32'h10000);
    end
    for (int i = 0; i < 4; i++) begin
      d = i == 3 ? ($urandom | 32'h2) : i;
      acc(1'b1, 16'h205B, 8'h00, d, 1'b0, 32'h0);
      idle(2);
      check(32'(d == 32'h1), {31'h0, pulse_cw_ccw_o});
      acc(1'b0, 16'h205B, 8'h00, 32'h0, 1'b0, d);
    end
    d = $urandom;
    acc(1'b1, 16'h2084, 8'h00, d, 1'b0, 32'h0);
    acc(1'b0, 16'h2084, 8'h00, 32'h0, 1'b0, d);
    idle(2);
    do_reset();
    acc(1'b0, 16'h2102, 8'h00, 32'h0, 1'b0, 32'h10012);
    idle(3);
    end_of_test();
  end
endmodule : dcfs_config_bank_tb
